// [logic/spc_boot_map.sv]
// Boot section start and application end from the two size fuses
`timescale 1ns/10ps
module spc_boot_map
  import spc_pkg::*;
(
  input  wire logic        boot_size_sel_hi,
  input  wire logic        boot_size_sel_lo,
  output logic [14:0]      boot_base,
  output logic [14:0]      app_last
);

  always_comb begin
    case ({boot_size_sel_hi, boot_size_sel_lo})
      2'b11: boot_base = SPC_BOOT_512;
      2'b10: boot_base = SPC_BOOT_1024;
      2'b01: boot_base = SPC_BOOT_2048;
      default: boot_base = SPC_BOOT_4096;
    endcase
    app_last = boot_base - 15'h0001;
  end

endmodule

// [logic/spc_control.sv]
// Self-programming control: register, timed command windows, buffer fill
// What this block does
// - Fuse bits pick boot size and start
// - Pages below 224 form the readable region
// - Fifteen-bit counter, 128-word pages
// - Page number comes from pointer bits 15:8
// - Pointer bits 7:1 pick buffer word
// - One 8-bit control/status register, reset zero
// - Ready interrupt while enabled and store clear
// - Erase/write to region sets busy flag
// - Busy clears on re-enable or buffer fill
// - Signature load window three, stores ignored
// - Re-enable only after operation finishes
// - Re-enable command discards buffered data
// - Plain store fills buffer from word data
// - Store within four cycles starts operation
// - Store enable auto-clears, held while busy
// - Only six command patterns take effect
`timescale 1ns/10ps
module spc_control
  import spc_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE1 = 8'hA1,  // Arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'hB2,  // Arbitrary value
  parameter logic [7:0] SIG_BYTE3 = 8'hC3,  // Arbitrary value
  parameter logic [7:0] CAL_BYTE  = 8'h80   // Arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  input  wire logic        global_irq_flag,
  input  wire logic        eeprom_write_pending,
  input  wire logic        store_instr,
  input  wire logic        load_instr,
  input  wire logic [15:0] pointer,
  input  wire logic [15:0] word_data,
  input  wire logic        boot_size_sel_hi,
  input  wire logic        boot_size_sel_lo,
  input  wire logic        flash_done,
  input  wire logic [6:0]  flash_buf_addr,
  output logic [15:0]      flash_buf_data,
  output logic             flash_erase_start,
  output logic             flash_write_start,
  output logic [7:0]       flash_page,
  output logic             region_busy_flag,
  output logic             ready_irq,
  output logic             load_override,
  output logic [7:0]       load_data,
  output logic [14:0]      boot_start,
  output logic [14:0]      app_end
);

  spc_state_t  state;
  logic        ready_irq_enable;
  logic        store_enable;
  logic        signature_read_cmd;
  logic        region_read_reenable;
  logic        lock_bits_set_cmd;
  logic        page_write_cmd;
  logic        page_erase_cmd;
  logic [2:0]  window_cnt;
  logic [14:0] boot_base;
  logic [14:0] app_last;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic       csr_write;
  logic [4:0] low_five;
  logic       pattern_ok;
  logic       accept_cmd;
  logic       store_take;
  logic       sig_take;
  logic       fill_take;
  logic       in_rww_page;
  logic [7:0] sig_byte;

  assign csr_write   = io_wr && (io_addr == SPC_CSR_ADDR);
  assign low_five    = io_wdata[4:0];
  assign pattern_ok  = (low_five == SPC_CMD_REENABLE || low_five == SPC_CMD_LOCK ||
                        low_five == SPC_CMD_WRITE || low_five == SPC_CMD_ERASE ||
                        low_five == SPC_CMD_FILL) &&
                       (!io_wdata[SPC_BIT_SIG] || low_five == SPC_CMD_FILL);
  // New commands only while idle and no EEPROM write is pending
  assign accept_cmd  = csr_write && pattern_ok && state == SPC_ST_IDLE && !eeprom_write_pending;
  assign store_take  = state == SPC_ST_ARMED && store_instr;
  assign sig_take    = state == SPC_ST_ARMED && signature_read_cmd && load_instr &&
                       window_cnt > (SPC_STORE_WINDOW - SPC_LOAD_WINDOW);
  // Plain fill: no other command bit set, pointer bit 0 ignored
  assign fill_take   = store_take && !signature_read_cmd && !region_read_reenable &&
                       !lock_bits_set_cmd && !page_write_cmd && !page_erase_cmd;
  assign in_rww_page = pointer[15:8] < SPC_RWW_PAGES;

  always_comb begin
    case (pointer[2:0])
      3'h0: sig_byte = SIG_BYTE1;
      3'h2: sig_byte = SIG_BYTE2;
      3'h4: sig_byte = SIG_BYTE3;
      3'h1: sig_byte = CAL_BYTE;
      default: sig_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state                <= SPC_ST_IDLE;
      store_enable         <= 1'b0;
      signature_read_cmd   <= 1'b0;
      region_read_reenable <= 1'b0;
      lock_bits_set_cmd    <= 1'b0;
      page_write_cmd       <= 1'b0;
      page_erase_cmd       <= 1'b0;
      window_cnt           <= 3'h0;
      flash_erase_start    <= 1'b0;
      flash_write_start    <= 1'b0;
      flash_page           <= 8'h00;
    end else if (clk_en) begin
      flash_erase_start <= 1'b0;
      flash_write_start <= 1'b0;
      case (state)
        SPC_ST_IDLE: begin
          if (accept_cmd) begin
            state                <= SPC_ST_ARMED;
            store_enable         <= 1'b1;
            signature_read_cmd   <= io_wdata[SPC_BIT_SIG];
            region_read_reenable <= io_wdata[4];
            lock_bits_set_cmd    <= io_wdata[3];
            page_write_cmd       <= io_wdata[2];
            page_erase_cmd       <= io_wdata[1];
            window_cnt           <= SPC_STORE_WINDOW;
          end
        end
        SPC_ST_ARMED: begin
          window_cnt <= window_cnt - 3'h1;
          if (store_take && (page_erase_cmd || page_write_cmd)) begin
            // Store enable stays high until the flash reports done
            state             <= SPC_ST_BUSY;
            flash_erase_start <= page_erase_cmd;
            flash_write_start <= page_write_cmd;
            flash_page        <= pointer[15:8];
          end else if ((store_take && !signature_read_cmd) || sig_take || window_cnt == 3'h1) begin
            // Command done, or the window ran out and it quietly expires
            state                <= SPC_ST_IDLE;
            store_enable         <= 1'b0;
            signature_read_cmd   <= 1'b0;
            region_read_reenable <= 1'b0;
            lock_bits_set_cmd    <= 1'b0;
            page_write_cmd       <= 1'b0;
            page_erase_cmd       <= 1'b0;
          end
        end
        SPC_ST_BUSY: begin
          if (flash_done) begin
            state          <= SPC_ST_IDLE;
            store_enable   <= 1'b0;
            page_write_cmd <= 1'b0;
            page_erase_cmd <= 1'b0;
          end
        end
        default: begin
          state <= SPC_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Region busy flag
  // ----------------------------------------------------------------
  logic start_rww;
  logic reenable_take;

  assign start_rww     = store_take && (page_erase_cmd || page_write_cmd) && in_rww_page;
  assign reenable_take = store_take && region_read_reenable;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      region_busy_flag <= 1'b0;
    end else if (clk_en) begin
      // A start outranks any clear landing in the same cycle
      if (start_rww) begin
        region_busy_flag <= 1'b1;
      end else if (reenable_take || fill_take) begin
        region_busy_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable, ready request and signature load
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ready_irq_enable <= 1'b0;
      ready_irq        <= 1'b0;
    end else if (clk_en) begin
      if (csr_write) begin
        ready_irq_enable <= io_wdata[SPC_BIT_IRQ_EN];
      end
      ready_irq <= ready_irq_enable && global_irq_flag && !store_enable;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      load_override <= 1'b0;
      load_data     <= 8'h00;
    end else if (clk_en) begin
      load_override <= sig_take;
      load_data     <= sig_take ? sig_byte : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Register read and boot map
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata <= SPC_CSR_RESET;
    end else if (clk_en) begin
      if (io_rd && io_addr == SPC_CSR_ADDR) begin
        io_rdata <= {ready_irq_enable, region_busy_flag, signature_read_cmd, region_read_reenable,
                     lock_bits_set_cmd, page_write_cmd, page_erase_cmd, store_enable};
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

  spc_boot_map u_boot_map (
    .boot_size_sel_hi (boot_size_sel_hi),
    .boot_size_sel_lo (boot_size_sel_lo),
    .boot_base        (boot_base),
    .app_last         (app_last)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      boot_start <= SPC_BOOT_4096;
      app_end    <= SPC_BOOT_4096 - 15'h0001;
    end else if (clk_en) begin
      boot_start <= boot_base;
      app_end    <= app_last;
    end
  end

  // ----------------------------------------------------------------
  // Page buffer; re-enable drops a partial load, page write consumes it
  // ----------------------------------------------------------------
  logic buf_discard;

  assign buf_discard = (accept_cmd && low_five == SPC_CMD_REENABLE) ||
                       (state == SPC_ST_BUSY && page_write_cmd && flash_done);

  spc_page_buffer u_page_buffer (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr_en   (fill_take),
    .wr_addr (pointer[7:1]),
    .wr_data (word_data),
    .discard (buf_discard),
    .rd_addr (flash_buf_addr),
    .rd_data (flash_buf_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ready_irq;
    @(posedge clock) disable iff (!reset_n)
      clk_en |=> ready_irq == $past(ready_irq_enable && global_irq_flag && !store_enable);
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("ready interrupt mismatch");

  property p_busy_set;
    @(posedge clock) disable iff (!reset_n)
      (flash_erase_start || flash_write_start) && flash_page < SPC_RWW_PAGES |-> region_busy_flag;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy flag not set on start");

  property p_fill_clears;
    @(posedge clock) disable iff (!reset_n)
      clk_en && fill_take |=> !region_busy_flag;
  endproperty
  a_fill_clears: assert property (p_fill_clears) else $error("fill did not clear busy");

  property p_start_page;
    @(posedge clock) disable iff (!reset_n)
      clk_en && store_take && page_erase_cmd |=> flash_erase_start && flash_page == $past(pointer[15:8]);
  endproperty
  a_start_page: assert property (p_start_page) else $error("erase start or page wrong");

  property p_held_busy;
    @(posedge clock) disable iff (!reset_n)
      state == SPC_ST_BUSY |-> store_enable;
  endproperty
  a_held_busy: assert property (p_held_busy) else $error("store enable dropped while busy");

  property p_window_end;
    @(posedge clock) disable iff (!reset_n)
      clk_en && state == SPC_ST_ARMED && window_cnt == 3'h1 && !store_instr && !load_instr
        |=> !store_enable && state == SPC_ST_IDLE;
  endproperty
  a_window_end: assert property (p_window_end) else $error("window did not expire");

  property p_sig_no_store;
    @(posedge clock) disable iff (!reset_n)
      clk_en && store_take && signature_read_cmd && !load_instr && window_cnt != 3'h1
        |=> !flash_erase_start && !flash_write_start && store_enable;
  endproperty
  a_sig_no_store: assert property (p_sig_no_store) else $error("store acted in signature mode");

  property p_bad_pattern;
    @(posedge clock) disable iff (!reset_n)
      clk_en && csr_write && !pattern_ok && state == SPC_ST_IDLE |=> !store_enable;
  endproperty
  a_bad_pattern: assert property (p_bad_pattern) else $error("invalid pattern took effect");

  property p_boot_small;
    @(posedge clock) disable iff (!reset_n)
      clk_en && boot_size_sel_hi && boot_size_sel_lo |=> boot_start == 15'h7E00 && app_end == 15'h7DFF;
  endproperty
  a_boot_small: assert property (p_boot_small) else $error("boot start wrong for 512 words");

endmodule

// [logic/spc_page_buffer.sv]
// Temporary page buffer with per-word fill marks
`timescale 1ns/10ps
module spc_page_buffer
  import spc_pkg::*;
#(
  parameter int WORDS = 128,
  parameter int WIDTH = 16,
  parameter int AW    = 7
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             discard,
  input  wire logic [AW-1:0]    rd_addr,
  output logic [WIDTH-1:0]      rd_data
);

  logic [WIDTH-1:0] mem [WORDS];
  logic [WORDS-1:0] filled;

  // ----------------------------------------------------------------
  // Storage; unfilled words read back as erased
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WORDS; i++) begin : g_mark
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          filled[i] <= 1'b0;
        end else if (clk_en) begin
          if (discard) begin
            filled[i] <= 1'b0;
          end else if (wr_en && wr_addr == AW'(i)) begin
            filled[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= filled[rd_addr] ? mem[rd_addr] : WIDTH'(SPC_ERASED_WORD);
    end
  end

endmodule

// [logic/spc_pkg.sv]
// Shared constants for the self-programming control block
package spc_pkg;

  // ----------------------------------------------------------------
  // Register map and control/status bit positions
  // ----------------------------------------------------------------
  localparam logic [5:0] SPC_CSR_ADDR    = 6'h37;
  localparam logic [7:0] SPC_CSR_RESET   = 8'h00;
  localparam int         SPC_BIT_IRQ_EN  = 7;
  localparam int         SPC_BIT_BUSY    = 6;
  localparam int         SPC_BIT_SIG     = 5;
  localparam int         SPC_BIT_STORE   = 0;

  // ----------------------------------------------------------------
  // Accepted low-five-bit command patterns
  // ----------------------------------------------------------------
  localparam logic [4:0] SPC_CMD_REENABLE = 5'h11;
  localparam logic [4:0] SPC_CMD_LOCK     = 5'h09;
  localparam logic [4:0] SPC_CMD_WRITE    = 5'h05;
  localparam logic [4:0] SPC_CMD_ERASE    = 5'h03;
  localparam logic [4:0] SPC_CMD_FILL     = 5'h01;

  // ----------------------------------------------------------------
  // Timed windows, in core clock cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] SPC_STORE_WINDOW = 3'h4;
  localparam logic [2:0] SPC_LOAD_WINDOW  = 3'h3;

  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam logic [7:0]  SPC_RWW_PAGES   = 8'hE0;
  localparam logic [15:0] SPC_ERASED_WORD = 16'hFFFF;
  localparam logic [14:0] SPC_BOOT_512    = 15'h7E00;
  localparam logic [14:0] SPC_BOOT_1024   = 15'h7C00;
  localparam logic [14:0] SPC_BOOT_2048   = 15'h7800;
  localparam logic [14:0] SPC_BOOT_4096   = 15'h7000;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPC_ST_IDLE  = 3'b001,
    SPC_ST_ARMED = 3'b010,
    SPC_ST_BUSY  = 3'b100
  } spc_state_t;

endpackage

// [testbench/spc_flash_model.sv]
// Behavioural flash array that answers erase and write starts
`timescale 1ns/10ps
module spc_flash_model (
  input  wire logic        clock,
  input  wire logic        slow,
  input  wire logic        flash_erase_start,
  input  wire logic        flash_write_start,
  input  wire logic [15:0] flash_buf_data,
  output logic [6:0]       flash_buf_addr,
  output logic             flash_done
);
  logic [15:0] img [128];

  // ------------------------------------------------------------
  // Array timing
  // ------------------------------------------------------------
  initial begin
    flash_buf_addr = 7'h00;
    flash_done     = 1'b0;
    forever begin
      @(negedge clock);
      if (flash_write_start === 1'b1) begin
        // One word per cycle, the buffer answers one edge after the address
        for (int i = 0; i < 128; i++) begin
          flash_buf_addr = i[6:0];
          @(negedge clock);
          img[i] = flash_buf_data;
        end
      end
      if (flash_write_start === 1'b1 || flash_erase_start === 1'b1 || flash_buf_addr === 7'h7F) begin
        flash_buf_addr = 7'h00;
        // A slow array keeps the operation busy, with store enable held, for many cycles
        repeat (slow ? 40 : 3) @(negedge clock);
        flash_done = 1'b1;
        @(negedge clock);
        flash_done = 1'b0;
      end
    end
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the self-programming control block
`timescale 1ns/10ps
module testbench;
  import spc_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clock = 1'b0, reset_n = 1'b0, clk_en = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
  logic        global_irq_flag = 1'b1, eeprom_write_pending = 1'b0, store_instr = 1'b0;
  logic        load_instr = 1'b0, boot_size_sel_hi = 1'b0, boot_size_sel_lo = 1'b0;
  logic        slow = 1'b0, io_chk = 1'b0, rd_q = 1'b0, chk_q = 1'b0;
  logic        flash_done, flash_erase_start, flash_write_start, region_busy_flag, ready_irq;
  logic        load_override;
  logic [5:0]  io_addr = 6'h00;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  io_rdata, flash_page, load_data, v, p;
  logic [6:0]  flash_buf_addr;
  logic [14:0] boot_start, app_end;
  logic [15:0] pointer = 16'h0000, word_data = 16'h0000;
  logic [15:0] flash_buf_data, b;
  logic [15:0] q[$];
  logic [15:0] d[128];
  logic [7:0]  bad[6]  = '{8'h07, 8'h13, 8'h1F, 8'h02, 8'h29, 8'h10};
  logic [7:0]  good[6] = '{8'h11, 8'h09, 8'h05, 8'h03, 8'h01, 8'h21};
  logic [7:0]  sig[4]  = '{8'h5A, 8'h6B, 8'h7C, 8'h8D};
  logic [15:0] zs[4]   = '{16'h0000, 16'h0002, 16'h0004, 16'h0001};
  int          seed = 74869, n_fail = 0, checks_done = 0, r;

  // Signature values are arbitrary
  spc_control #(.SIG_BYTE1(8'h5A), .SIG_BYTE2(8'h6B), .SIG_BYTE3(8'h7C), .CAL_BYTE(8'h8D)) i_spc_control (
    .clock, .reset_n, .clk_en, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .global_irq_flag,
    .eeprom_write_pending, .store_instr, .load_instr, .pointer, .word_data, .boot_size_sel_hi,
    .boot_size_sel_lo, .flash_done, .flash_buf_addr, .flash_buf_data, .flash_erase_start,
    .flash_write_start, .flash_page, .region_busy_flag, .ready_irq, .load_override, .load_data,
    .boot_start, .app_end);
  spc_flash_model i_spc_flash_model (
    .clock, .slow, .flash_erase_start, .flash_write_start, .flash_buf_data, .flash_buf_addr, .flash_done);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] nxt();
    return (q.size() > 0) ? q.pop_front() : 16'hXXXX;
  endfunction

  task automatic wr(input logic [7:0] dat, input logic [5:0] a = SPC_CSR_ADDR);
    io_addr = a;
    io_wdata = dat;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
  endtask

  // Two cycles per read so the strobe never rises in the step it fell
  task automatic rd(input logic chk, input logic [7:0] e);
    io_addr = SPC_CSR_ADDR;
    io_rd = 1'b1;
    io_chk = chk;
    if (chk)
      q.push_back({8'h00, e});
    @(negedge clock);
    io_rd = 1'b0;
    io_chk = 1'b0;
    v = io_rdata;
    @(negedge clock);
  endtask

  task automatic poll();
    v = 8'hFF;
    for (int n = 0; n < 100 && v[0] !== 1'b0; n++)
      rd(1'b0, 8'h00);
  endtask

  task automatic spm(input logic [7:0] c, input logic [15:0] ptr, input logic [15:0] dat, input int gap);
    poll();
    wr(c);
    repeat (gap - 1) @(negedge clock);
    pointer = ptr;
    word_data = dat;
    store_instr = 1'b1;
    @(negedge clock);
    store_instr = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, monitor and watchdog
  // ------------------------------------------------------------
  initial begin
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    rd_q <= io_rd;
    chk_q <= io_chk;
  end

  always @(negedge clock) begin
    if (rd_q && chk_q)
      check({8'h00, io_rdata}, nxt());
    if (load_override === 1'b1)
      check({8'h00, load_data}, nxt());
    if (flash_erase_start === 1'b1 || flash_write_start === 1'b1)
      check({8'h00, flash_page}, nxt());
  end

  initial begin
    #(4 * 40000);
    n_fail++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    for (int f = 0; f < 4; f++) begin
      {boot_size_sel_hi, boot_size_sel_lo} = f[1:0];
      repeat (2) @(negedge clock);
      b = 16'h8000 - (16'h0200 << (3 - f));
      check({1'b0, boot_start}, b);
      check({1'b0, app_end}, b - 16'h0001);
    end
    $display("test boot map done");
    rd(1'b1, SPC_CSR_RESET);
    wr(8'h03, 6'h36);
    rd(1'b1, 8'h00);
    eeprom_write_pending = 1'b1;
    wr(8'h03);
    rd(1'b1, 8'h00);
    eeprom_write_pending = 1'b0;
    foreach (bad[i]) begin
      wr(bad[i]);
      rd(1'b1, 8'h00);
    end
    foreach (good[i]) begin
      wr(good[i]);
      rd(1'b1, good[i]);
      repeat (4) @(negedge clock);
      rd(1'b1, 8'h00);
    end
    $display("test command patterns done");
    // Erase a readable page with a slow array, then run the full program order
    r = $random(seed);
    p = r[7:0] % 8'hE0;
    slow = 1'b1;
    q.push_back({8'h00, p});
    spm(8'h83, {p, 8'h00}, 16'h0000, 1);
    @(negedge clock);
    check(16'(region_busy_flag), 16'h0001);
    check(16'(ready_irq), 16'h0000);
    rd(1'b1, 8'hC3);
    wr(8'h91);
    rd(1'b1, 8'hC3);
    poll();
    check(16'(ready_irq), 16'h0001);
    global_irq_flag = 1'b0;
    repeat (2) @(negedge clock);
    check(16'(ready_irq), 16'h0000);
    global_irq_flag = 1'b1;
    spm(8'h01, {p, 8'hFE}, 16'h1234, 1);
    @(negedge clock);
    check(16'(region_busy_flag), 16'h0000);
    spm(8'h11, {p, 8'h00}, 16'h0000, 1);
    for (int i = 0; i < 127; i++) begin
      d[i] = 16'($random(seed));
      spm(8'h01, {p, i[6:0], 1'b0}, d[i], 1);
    end
    slow = 1'b0;
    q.push_back({8'h00, p});
    spm(8'h05, {p, 8'h00}, 16'h0000, 1);
    @(negedge clock);
    check(16'(region_busy_flag), 16'h0001);
    // Only the register is touched while busy, as code in the blocking region would
    poll();
    for (int n = 0; n < 4 && region_busy_flag === 1'b1; n++)
      spm(8'h11, {p, 8'h00}, 16'h0000, 1);
    @(negedge clock);
    check(16'(region_busy_flag), 16'h0000);
    for (int i = 0; i < 127; i++)
      check(i_spc_flash_model.img[i], d[i]);
    check(i_spc_flash_model.img[127], 16'hFFFF);
    $display("test page program done");
    r = $random(seed);
    p = 8'hE0 + {3'h0, r[4:0]};
    q.push_back({8'h00, p});
    spm(8'h03, {p, 8'h00}, 16'h0000, 1);
    @(negedge clock);
    check(16'(region_busy_flag), 16'h0000);
    q.push_back({8'h00, p});
    spm(8'h03, {p, 8'h00}, 16'h0000, 4);
    spm(8'h03, {p, 8'h00}, 16'h0000, 5);
    rd(1'b1, 8'h00);
    spm(8'h09, 16'h0000, 16'h00FF, 1);
    rd(1'b1, 8'h00);
    // Clock enable low must freeze the window count
    poll();
    wr(8'h11);
    clk_en = 1'b0;
    repeat (6) @(negedge clock);
    clk_en = 1'b1;
    rd(1'b1, 8'h11);
    repeat (4) @(negedge clock);
    rd(1'b1, 8'h00);
    $display("test windows done");
    // Stores in signature mode must start nothing while the load answers
    for (int k = 0; k < 4; k++) begin
      q.push_back({8'h00, sig[k]});
      poll();
      wr(8'h21);
      pointer = zs[k] & 16'hFFFE;
      store_instr = 1'b1;
      @(negedge clock);
      store_instr = 1'b0;
      pointer = zs[k];
      load_instr = 1'b1;
      @(negedge clock);
      load_instr = 1'b0;
    end
    poll();
    wr(8'h21);
    repeat (3) @(negedge clock);
    load_instr = 1'b1;
    @(negedge clock);
    load_instr = 1'b0;
    repeat (3) @(negedge clock);
    check(16'(q.size()), 16'h0000);
    $display("test signature done");
    report_and_stop();
  end
endmodule
